// [rtl/core_tick_down_counter.sv]
// tick down counter with reload, zero flag and register port
// ****************************************
// Notes on behaviour
// - zero reloads counter from 24-bit reload value
// - control bit 0 enables counting, resets 0
// - control bit 1 gates tick interrupt at zero
// - control bit 2: 1 full clock, 0 half
// - flag bit 16 reports zero, read clears
// - current value read returns 24-bit count
// - current value write clears count and flag
// - four registers at 0x010..0x01c, calibration resets 4
// - half rate made internally, no pins used
// - calibration comes from configuration block value
// ****************************************
`timescale 1ns/1ps
module core_tick_down_counter #(
  parameter int COUNT_WIDTH = tick_timer_pkg::COUNT_W
) (
  // clock, reset and freeze
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register port from the core
  input  wire logic        reg_req,
  input  wire logic        reg_write,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // calibration from the system configuration block
  input  wire logic [31:0] calibration_source_value,
  // tick interrupt to the core
  output logic             tick_irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;          // down counter
    logic [COUNT_WIDTH-1:0] reload;         // reload value
    logic                   enable;         // counting enable
    logic                   irq_en;         // zero_irq_enable
    logic                   clk_sel;        // count_clock_select
    logic                   flag;           // zero_reached_flag
    logic [31:0]            calib;          // calibration image
    logic [31:0]            rdata;          // read data register
    logic                   ack;            // answer strobe
    logic                   irq;            // interrupt pulse
  } tick_state_t;

  tick_state_t st_q;                        // registered state
  tick_state_t st_d;                        // next state
  logic        count_tick;                  // count strobe from the gate
  logic        zero_hit;                    // counter steps from one to zero
  logic        reload_hit;                  // counter at zero reloads
  logic        wr_csr;                      // write to control and status
  logic        wr_rvr;                      // write to reload value
  logic        wr_cvr;                      // write to current value
  logic        rd_csr;                      // read of control and status
  logic        rd_cvr;                      // read of current value

  // ****************************************
  // count rate
  // ****************************************
  // half rate strobe, no external pin and no second clock
  tick_rate_gate u_gate (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .full_rate (st_q.clk_sel),
    .tick      (count_tick)
  );

  // ****************************************
  // next state
  // ****************************************
  // one combinational pass over every field of the state
  always_comb begin
    st_d   = st_q;
    wr_csr = reg_req && reg_write && (reg_addr == tick_timer_pkg::OFF_CONTROL_STATUS);
    wr_rvr = reg_req && reg_write && (reg_addr == tick_timer_pkg::OFF_RELOAD_VALUE);
    wr_cvr = reg_req && reg_write && (reg_addr == tick_timer_pkg::OFF_CURRENT_VALUE);
    rd_csr = reg_req && !reg_write && (reg_addr == tick_timer_pkg::OFF_CONTROL_STATUS);
    rd_cvr = reg_req && !reg_write && (reg_addr == tick_timer_pkg::OFF_CURRENT_VALUE);
    // counting only while enabled and on the selected strobe
    zero_hit   = st_q.enable && count_tick && !wr_cvr
                 && (st_q.count == COUNT_WIDTH'(1));
    reload_hit = st_q.enable && count_tick && !wr_cvr && (st_q.count == '0);

    // counter: write clears, zero reloads, otherwise step down
    if (wr_cvr) begin
      st_d.count = '0;
    end else if (reload_hit) begin
      st_d.count = st_q.reload;
    end else if (st_q.enable && count_tick) begin
      st_d.count = st_q.count - COUNT_WIDTH'(1);
    end

    // flag: a zero event in the same cycle beats the read clear; a current value write blocks the zero event
    if (zero_hit) begin
      st_d.flag = 1'b1;
    end else if (rd_csr || wr_cvr) begin
      st_d.flag = 1'b0;
    end

    // interrupt pulse only when enabled, for one cycle per zero
    st_d.irq = zero_hit && st_q.irq_en;

    // control fields; reserved bits are left to software
    if (wr_csr) begin
      st_d.enable  = reg_wdata[tick_timer_pkg::BIT_ENABLE];
      st_d.irq_en  = reg_wdata[tick_timer_pkg::BIT_IRQ_ENABLE];
      st_d.clk_sel = reg_wdata[tick_timer_pkg::BIT_CLOCK_SELECT];
    end
    if (wr_rvr) begin
      st_d.reload = reg_wdata[COUNT_WIDTH-1:0];
    end

    // calibration follows the configuration value; writes do nothing
    st_d.calib = '0;
    st_d.calib[tick_timer_pkg::TEN_MILLI_MSB:0] =
      calibration_source_value[tick_timer_pkg::TEN_MILLI_MSB:0];
    st_d.calib[tick_timer_pkg::BIT_SKEW]   = calibration_source_value[tick_timer_pkg::BIT_SKEW];
    st_d.calib[tick_timer_pkg::BIT_NO_REF] = calibration_source_value[tick_timer_pkg::BIT_NO_REF];

    // every request gets one answer; unmapped reads return zero
    st_d.ack   = reg_req;
    st_d.rdata = '0;
    if (reg_req && !reg_write) begin
      unique case (reg_addr)
        tick_timer_pkg::OFF_CONTROL_STATUS: begin
          st_d.rdata[tick_timer_pkg::BIT_ENABLE]       = st_q.enable;
          st_d.rdata[tick_timer_pkg::BIT_IRQ_ENABLE]   = st_q.irq_en;
          st_d.rdata[tick_timer_pkg::BIT_CLOCK_SELECT] = st_q.clk_sel;
          st_d.rdata[tick_timer_pkg::BIT_ZERO_FLAG]    = st_q.flag;
        end
        tick_timer_pkg::OFF_RELOAD_VALUE: begin
          st_d.rdata[COUNT_WIDTH-1:0] = st_q.reload;
        end
        tick_timer_pkg::OFF_CURRENT_VALUE: begin
          st_d.rdata[COUNT_WIDTH-1:0] = st_q.count;
        end
        tick_timer_pkg::OFF_CALIBRATION: begin
          st_d.rdata = st_q.calib;
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // synchronous reset; low clock enable freezes everything
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q         <= '0;
      st_q.enable  <= tick_timer_pkg::CONTROL_RESET[tick_timer_pkg::BIT_ENABLE];
      st_q.irq_en  <= tick_timer_pkg::CONTROL_RESET[tick_timer_pkg::BIT_IRQ_ENABLE];
      st_q.clk_sel <= tick_timer_pkg::CONTROL_RESET[tick_timer_pkg::BIT_CLOCK_SELECT];
      st_q.reload  <= tick_timer_pkg::RELOAD_RESET[COUNT_WIDTH-1:0];
      st_q.count   <= tick_timer_pkg::CURRENT_RESET[COUNT_WIDTH-1:0];
      st_q.calib   <= tick_timer_pkg::CALIB_RESET;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = st_q.rdata;
  assign reg_ack   = st_q.ack;
  assign tick_irq  = st_q.irq;

  // ****************************************
  // checks
  // ****************************************
  // a counting cycle with the counter at zero
  sequence s_reload_cycle;
    ce && reload_hit;
  endsequence

  // a read of control and status with no zero event beside it
  sequence s_quiet_status_read;
    ce && rd_csr && !zero_hit;
  endsequence

  property p_reload;
    @(posedge mclk) disable iff (rst)
    s_reload_cycle |=> (st_q.count == $past(st_q.reload));
  endproperty
  a_reload: assert property (p_reload) else $error("counter did not reload at zero");

  property p_stopped;
    @(posedge mclk) disable iff (rst)
    (ce && !st_q.enable && !wr_cvr) |=> $stable(st_q.count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while disabled");

  property p_irq_fire;
    @(posedge mclk) disable iff (rst)
    (ce && zero_hit) |=> (tick_irq == $past(st_q.irq_en));
  endproperty
  a_irq_fire: assert property (p_irq_fire) else $error("interrupt does not follow enable");

  property p_half_rate;
    @(posedge mclk) disable iff (rst)
    (ce && count_tick && !st_q.clk_sel) |=> (count_tick == st_q.clk_sel);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate strobe twice in a row");

  property p_flag_clear;
    @(posedge mclk) disable iff (rst)
    s_quiet_status_read |=> (!st_q.flag && reg_ack
      && reg_rdata[tick_timer_pkg::BIT_ZERO_FLAG] == $past(st_q.flag));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag read or clear wrong");

  property p_current_read;
    @(posedge mclk) disable iff (rst)
    (ce && rd_cvr) |=> (reg_rdata[COUNT_WIDTH-1:0] == $past(st_q.count));
  endproperty
  a_current_read: assert property (p_current_read) else $error("current value read wrong");

  property p_current_write;
    @(posedge mclk) disable iff (rst)
    (ce && wr_cvr) |=> (st_q.count == '0 && !st_q.flag);
  endproperty
  a_current_write: assert property (p_current_write) else $error("write did not clear");

  property p_calib;
    @(posedge mclk) disable iff (rst)
    (ce && reg_req && !reg_write && reg_addr == tick_timer_pkg::OFF_CALIBRATION)
      |=> (reg_ack && reg_rdata == $past(st_q.calib));
  endproperty
  a_calib: assert property (p_calib) else $error("calibration read wrong");

  // a low clock enable holds every field, counter, flag and answer alike
  property p_freeze;
    @(posedge mclk) disable iff (rst)
    !ce |=> $stable(st_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule

// [rtl/tick_rate_gate.sv]
// count clock enable: full system rate or every second cycle
`timescale 1ns/1ps
module tick_rate_gate (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // control
  input  wire logic full_rate,
  // count strobe
  output logic      tick
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic phase;                            // high on every second cycle
  } gate_state_t;

  gate_state_t st_q;                        // registered state
  gate_state_t st_d;                        // next state

  // a phase toggle keeps the half rate inside the one clock domain
  always_comb begin
    st_d       = st_q;
    st_d.phase = ~st_q.phase;
  end

  // registers freeze while the clock enable is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // full rate strobes every cycle, half rate only on the phase
  assign tick = full_rate | st_q.phase;

endmodule

// [rtl/tick_timer_pkg.sv]
// constants shared by the tick down counter design
package tick_timer_pkg;

  // ****************************************
  // counter geometry
  // ****************************************
  localparam int COUNT_W = 24;              // down counter and reload width
  localparam int ADDR_W  = 12;              // register port address width
  localparam int DATA_W  = 32;              // register port data width

  // ****************************************
  // register offsets from the timer base
  // ****************************************
  localparam logic [11:0] OFF_CONTROL_STATUS = 12'h010;
  localparam logic [11:0] OFF_RELOAD_VALUE   = 12'h014;
  localparam logic [11:0] OFF_CURRENT_VALUE  = 12'h018;
  localparam logic [11:0] OFF_CALIBRATION    = 12'h01c;

  // ****************************************
  // control and status field positions
  // ****************************************
  localparam int BIT_ENABLE       = 0;      // counting enable
  localparam int BIT_IRQ_ENABLE   = 1;      // zero_irq_enable
  localparam int BIT_CLOCK_SELECT = 2;      // count_clock_select
  localparam int BIT_ZERO_FLAG    = 16;     // zero_reached_flag

  // ****************************************
  // calibration field positions and reset
  // ****************************************
  localparam int TEN_MILLI_MSB   = 23;      // ten_milli_count upper bit
  localparam int BIT_SKEW        = 30;      // skew indicator
  localparam int BIT_NO_REF      = 31;      // no_reference_indicator
  localparam logic [31:0] CALIB_RESET = 32'h0000_0004;

  // ****************************************
  // reset values of the writable fields
  // ****************************************
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RESET  = 32'h0000_0000;
  localparam logic [31:0] CURRENT_RESET = 32'h0000_0000;

endpackage

// [verif/core_bus_model.sv]
// core-side register master model for the tick down counter
`timescale 1ns/1ps
module core_bus_model (
  // clock
  input  wire logic        mclk,
  // register port
  output logic             reg_req,
  output logic             reg_write,
  output logic      [11:0] reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack
);
  // ****************************************
  // software keeps reserved positions at zero
  // ****************************************
  function automatic logic [31:0] keep(input logic [11:0] a);
    case (a)
      12'h010: return 32'h0000_0007;
      12'h014, 12'h018: return 32'h00ff_ffff;
      default: return 32'hffff_ffff;
    endcase
  endfunction

  // ****************************************
  // one access: drive after a falling edge, take the answer a cycle on
  // ****************************************
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ack);
    @(negedge mclk);
    reg_req   = 1'b1;
    reg_write = wr;
    reg_addr  = a;
    reg_wdata = d & keep(a);
    @(negedge mclk);
    ack       = reg_ack;
    rd        = reg_rdata;
    reg_req   = 1'b0;
    // released lines must not keep showing the old value
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // idle port at time zero
  initial begin
    reg_req   = 1'b0;
    reg_write = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 32'h0000_0000;
  end
endmodule

// [verif/core_tick_down_counter_tb.sv]
// self-checking bench for the tick down counter
`timescale 1ns/1ps
module core_tick_down_counter_tb;
  // ****************************************
  // wiring and bookkeeping
  // ****************************************
  logic        mclk;
  logic        rst;
  logic        ce;
  logic        reg_req;
  logic        reg_write;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_ack;
  logic [31:0] cal_src;
  logic        tick_irq;
  logic [31:0] rd;
  logic [31:0] rl;
  logic [31:0] v;
  int          n;
  int          err_total;
  int          cmp_count;

  // 200 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  core_tick_down_counter #(.COUNT_WIDTH(24)) u_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .calibration_source_value(cal_src), .tick_irq(tick_irq));

  core_bus_model u_core (
    .mclk(mclk), .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

  // ****************************************
  // shared tasks and expectations
  // ****************************************
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // every request must be answered, whatever the address
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic ack;
    u_core.access(wr, a, d, rd, ack);
    check({31'h0, ack}, 32'h1, "answer");
  endtask

  // cycles up to the next interrupt pulse; a missing pulse ends the run
  task automatic irq_gap(output int cyc);
    cyc = 0;
    do begin
      @(negedge mclk);
      cyc++;
    end while (tick_irq !== 1'b1 && cyc < 200);
    if (cyc >= 200) begin
      err_total++;
      $display("CHECK FAILED at %0t: no interrupt pulse", $time);
      end_of_test();
    end
  endtask

  // strobes per period are reload plus one; half rate doubles the cycles
  function automatic logic [31:0] period(input logic [31:0] r, input logic full);
    return full ? r + 32'h1 : 32'h2 * (r + 32'h1);
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_total = 0;
    cmp_count = 0;
    void'($urandom(3));
    cal_src = $urandom();
    rst = 1'b1;
    ce  = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    // reset values, calibration mirror, refused write and an unmapped place
    acc(0, 12'h010, 0);
    check(rd, 32'h0000_0000, "control reset");
    acc(0, 12'h014, 0);
    check(rd, 32'h0000_0000, "reload reset");
    acc(0, 12'h018, 0);
    check(rd, 32'h0000_0000, "count reset");
    acc(1, 12'h01c, 32'h0000_0000);
    acc(0, 12'h01c, 0);
    check(rd, cal_src & 32'hc0ff_ffff, "calibration");
    acc(0, 12'h020, 0);
    check(rd, 32'h0000_0000, "unmapped");
    $display("test registers at reset done");
    // reload read-back, widest value first
    for (int i = 0; i < 4; i++) begin
      rl = (i == 0) ? 32'h00ff_ffff : $urandom() & 32'h00ff_ffff;
      acc(1, 12'h014, rl);
      acc(0, 12'h014, 0);
      check(rd, rl, "reload readback");
    end
    $display("test reload register done");
    // period at full rate then half rate, flag seen afterwards
    for (int m = 0; m < 2; m++) begin
      rl = 32'($urandom_range(6, 1));
      acc(1, 12'h014, rl);
      acc(1, 12'h018, $urandom());
      acc(1, 12'h010, (m == 0) ? 32'h0000_0007 : 32'h0000_0003);
      irq_gap(n);
      irq_gap(n);
      check(32'(n), period(rl, m == 0), "period");
      acc(0, 12'h010, 0);
      check(rd & 32'h0001_0007, {15'h0, 1'b1, 13'h0, m == 0, 2'h3}, "flag");
    end
    $display("test count periods done");
    // interrupt masked, then stop and clear count and flag
    acc(1, 12'h010, 32'h0000_0005);
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      if (tick_irq === 1'b1) n++;
    end
    check(32'(n), 32'h0, "masked interrupt");
    acc(1, 12'h010, 32'h0000_0000);
    acc(1, 12'h018, $urandom());
    acc(0, 12'h010, 0);
    check(rd, 32'h0000_0000, "flag cleared");
    acc(0, 12'h018, 0);
    check(rd, 32'h0000_0000, "count cleared");
    $display("test masked and cleared done");
    // count runs from the reload, then holds once disabled
    acc(1, 12'h014, 32'h0000_0100);
    acc(1, 12'h010, 32'h0000_0005);
    repeat (20) @(negedge mclk);
    acc(1, 12'h010, 32'h0000_0000);
    acc(0, 12'h018, 0);
    v = rd;
    check({31'h0, v > 32'h0000_00e0 && v < 32'h0000_0100}, 32'h1, "count range");
    acc(0, 12'h018, 0);
    check(rd, v, "count held");
    $display("test enable and hold done");
    // low clock enable mid-run: the count keeps its value until it returns
    acc(1, 12'h010, 32'h0000_0005);
    acc(0, 12'h018, 0);
    v = rd;
    ce = 1'b0;
    repeat (30) @(negedge mclk);
    ce = 1'b1;
    acc(0, 12'h018, 0);
    check(rd, v - 32'h2, "count frozen");
    // reset in mid-run with the clock enable low: reset still wins
    rst = 1'b1;
    ce  = 1'b0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    ce  = 1'b1;
    acc(0, 12'h010, 0);
    check(rd, 32'h0000_0000, "control after reset");
    acc(0, 12'h018, 0);
    check(rd, 32'h0000_0000, "count after reset");
    // software copies the calibration count into reload at its intended clock
    acc(0, 12'h01c, 0);
    acc(1, 12'h014, rd & 32'h00ff_ffff);
    acc(0, 12'h014, 0);
    check(rd, cal_src & 32'h00ff_ffff, "calibration copied");
    $display("test freeze, reset and calibration copy done");
    end_of_test();
  end
endmodule
